// ===== logic/mirc_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "mirc_defs.svh"

// How it works
// - only levels 2,3,5,7,10,11 reach host
// - stored levels are copied into routing registers
// - channels A-D own lines, E-H share one
// - status register sits at port A plus 0x400
// - port addresses come from the storage
// - control block decoded at jumper base
// - levels at locations 9-C, shared at D
// - load at power-on and on load write
// - address byte is host A9..A3
module mirc_top
    import mirc_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [15:0] io_addr,
    input wire logic io_wr_strobe,
    input wire logic io_rd_strobe,
    input wire logic [7:0] io_wdata,
    input wire logic [5:0] base_jumper_pins,
    input wire logic port_disable_pin,
    input wire logic [7:0] uart_irq,
    output logic [7:0] io_rdata,
    output logic io_rdata_oe,
    output logic [7:0] uart_sel,
    output logic [15:0] host_irq,
    output logic load_busy
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // true for the six levels the host bus may carry
    function automatic logic irq_legal(input logic [3:0] lvl);
        logic [15:0] mask;
        mask = `MIRC_IRQ_LEGAL_MASK;
        irq_legal = mask[lvl];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // jumper synchroniser: three stages, accept when last two agree

    logic [6:0] jmp_s1_r; // first stage, read only by the second
    logic [6:0] jmp_s2_r;
    logic [6:0] jmp_s3_r;
    logic [6:0] jmp_r; // accepted jumper value
    wire [5:0] cb_base = jmp_r[5:0]; // control block A9..A4
    wire ports_off = jmp_r[6]; // ports hidden while set

    // jumpers are static, but filtering avoids a bounce mis-decoding
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            jmp_s1_r <= `MIRC_RST_JUMPERS;
            jmp_s2_r <= `MIRC_RST_JUMPERS;
            jmp_s3_r <= `MIRC_RST_JUMPERS;
            jmp_r <= `MIRC_RST_JUMPERS;
        end else begin
            jmp_s1_r <= {port_disable_pin, base_jumper_pins};
            jmp_s2_r <= jmp_s1_r;
            jmp_s3_r <= jmp_s2_r;
            if (jmp_s2_r == jmp_s3_r) begin
                jmp_r <= jmp_s3_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control block decode

    wire cb_hit = (io_addr[15:10] == 6'h00) && (io_addr[9:4] == cb_base);
    wire [3:0] cb_ofs = io_addr[3:0];
    wire wr_ee_addr = io_wr_strobe && cb_hit && (cb_ofs == `MIRC_OFS_EE_ADDR);
    wire wr_ee_data = io_wr_strobe && cb_hit && (cb_ofs == `MIRC_OFS_EE_DATA);
    wire wr_load = io_wr_strobe && cb_hit && (cb_ofs == `MIRC_OFS_LOAD);
    wire rd_ee_addr = io_rd_strobe && cb_hit && (cb_ofs == `MIRC_OFS_EE_ADDR);
    wire rd_ee_data = io_rd_strobe && cb_hit && (cb_ofs == `MIRC_OFS_EE_DATA);

    ////////////////////////////////////////////////////////////////////////////
    // configuration storage

    logic [3:0] ee_addr_r; // storage pointer
    logic [7:0] ee_mem [16]; // non-volatile bytes, no reset on purpose
    logic [15:0] ee_valid_r; // location written since reset

    // storage contents survive reset, so the array has no reset branch
    always_ff @(posedge core_clk) begin
        if (wr_ee_data) begin
            ee_mem[ee_addr_r] <= io_wdata;
        end
    end

    // pointer and written flags; unwritten bytes are never loaded
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ee_addr_r <= `MIRC_RST_EE_ADDR;
            ee_valid_r <= 16'h0000;
        end else begin
            if (wr_ee_addr) begin
                ee_addr_r <= io_wdata[3:0];
            end
            if (wr_ee_data) begin
                ee_valid_r[ee_addr_r] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // loader: walks locations 1..d, one per cycle

    mirc_state_t state_r;
    logic [3:0] ld_idx_r; // location being copied
    logic [6:0] port_addr_r [8]; // port base A9..A3 per channel
    logic [3:0] irq_lvl_r [5]; // levels for A, B, C, D and shared E-H
    wire ld_live = (state_r == mirc_st_load) && ee_valid_r[ld_idx_r];
    wire ld_is_addr = (ld_idx_r <= `MIRC_LOC_ADDR_LAST);
    wire [2:0] ld_ch = 3'(ld_idx_r - `MIRC_LOC_ADDR_FIRST);
    wire [2:0] ld_grp = 3'(ld_idx_r - `MIRC_LOC_IRQ_FIRST);

    assign load_busy = state_r; // straight from the state flop

    // state and walk pointer; a load write restarts a walk in progress
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            state_r <= mirc_st_load;
            ld_idx_r <= `MIRC_LOC_ADDR_FIRST;
        end else if (wr_load) begin
            state_r <= mirc_st_load;
            ld_idx_r <= `MIRC_LOC_ADDR_FIRST;
        end else begin
            unique case (state_r)
                mirc_st_idle: begin
                    ld_idx_r <= `MIRC_LOC_ADDR_FIRST;
                end
                mirc_st_load: begin
                    if (ld_idx_r == `MIRC_LOC_IRQ_SHARED) begin
                        state_r <= mirc_st_idle;
                    end
                    ld_idx_r <= 4'(ld_idx_r + 4'h1);
                end
            endcase
        end
    end

    // copy one stored byte into the active routing registers
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            for (int i = 0; i < 8; i++) begin
                port_addr_r[i] <= `MIRC_RST_PORT_ADDR;
            end
            for (int g = 0; g < 5; g++) begin
                irq_lvl_r[g] <= `MIRC_RST_IRQ; // unrouted until loaded
            end
        end else if (ld_live) begin
            if (ld_is_addr) begin
                port_addr_r[ld_ch] <= ee_mem[ld_idx_r][6:0];
            end else begin
                irq_lvl_r[ld_grp] <= ee_mem[ld_idx_r][3:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // port and status decode

    logic [7:0] port_hit;
    wire [15:0] stat_addr = 16'({6'h00, port_addr_r[0], 3'h0} + `MIRC_STATUS_ALIAS);
    wire stat_rd = io_rd_strobe && (io_addr == stat_addr);

    // A10 and up must be zero, which keeps the alias off channel A
    always_comb begin
        for (int c = 0; c < 8; c++) begin
            port_hit[c] = (io_addr[15:10] == 6'h00)
                && (io_addr[9:3] == port_addr_r[c]);
        end
    end

    // pending groups: four own lines, one shared by E-H
    wire [4:0] grp_pend = {|uart_irq[7:4], uart_irq[3:0]};
    logic [15:0] host_irq_nxt;

    // a group with an illegal level drives nothing at all
    always_comb begin
        host_irq_nxt = 16'h0000;
        for (int g = 0; g < 5; g++) begin
            if (grp_pend[g] && irq_legal(irq_lvl_r[g])) begin
                host_irq_nxt[irq_lvl_r[g]] = 1'b1;
            end
        end
    end

    wire [7:0] rdata_nxt = stat_rd ? uart_irq
        : rd_ee_addr ? {4'h0, ee_addr_r}
        : (rd_ee_data && ee_valid_r[ee_addr_r]) ? ee_mem[ee_addr_r]
        : rd_ee_data ? `MIRC_EE_ERASED
        : 8'h00;
    wire rdata_oe_nxt = stat_rd || rd_ee_addr || rd_ee_data;
    wire [7:0] sel_nxt = (io_rd_strobe || io_wr_strobe) && !ports_off ? port_hit : 8'h00;

    // registered outputs, one cycle behind the bus strobe
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            io_rdata <= 8'h00;
            io_rdata_oe <= 1'b0;
            uart_sel <= 8'h00;
            host_irq <= 16'h0000;
        end else begin
            io_rdata <= rdata_nxt;
            io_rdata_oe <= rdata_oe_nxt;
            uart_sel <= sel_nxt;
            host_irq <= host_irq_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb_chk @(posedge core_clk); endclocking
    default disable iff (!resetn);

    chk_irq_only_legal: assert property (
        (host_irq & ~`MIRC_IRQ_LEGAL_MASK) == 16'h0000)
        else $error("irq driven on an unsupported level");
    chk_own_line_a: assert property (
        uart_irq[0] && irq_legal(irq_lvl_r[0]) |=> host_irq[$past(irq_lvl_r[0])])
        else $error("channel a pending but its line stayed low");
    chk_shared_line: assert property (
        uart_irq[6] && irq_legal(irq_lvl_r[4]) |=> host_irq[$past(irq_lvl_r[4])])
        else $error("channel g pending but shared line stayed low");
    chk_status_bits: assert property (
        stat_rd |=> io_rdata_oe && (io_rdata == $past(uart_irq)))
        else $error("status read did not return pending bits");
    chk_alias_not_port: assert property (
        stat_rd |=> !uart_sel[0])
        else $error("status alias selected channel a");
    chk_port_decode: assert property (
        io_rd_strobe && !ports_off && io_addr[15:3] == {6'h00, port_addr_r[2]}
        |=> uart_sel[2])
        else $error("channel c not selected at its base");
    chk_cb_addr_wr: assert property (
        wr_ee_addr |=> ee_addr_r == $past(io_wdata[3:0]))
        else $error("storage pointer not written at control block");
    chk_load_busy: assert property (
        wr_load |=> load_busy[*8])
        else $error("load write did not start a walk");
    chk_power_on: assert property (
        $rose(resetn) |-> load_busy)
        else $error("no load after reset");
    chk_irq_copy: assert property (
        state_r == mirc_st_load && ld_idx_r == `MIRC_LOC_IRQ_SHARED
        && ee_valid_r[`MIRC_LOC_IRQ_SHARED] && !wr_load
        |=> irq_lvl_r[4] == $past(ee_mem[`MIRC_LOC_IRQ_SHARED][3:0]))
        else $error("shared level not copied from location d");
    chk_addr_copy: assert property (
        state_r == mirc_st_load && ld_idx_r == `MIRC_LOC_ADDR_FIRST
        && ee_valid_r[`MIRC_LOC_ADDR_FIRST] && !wr_load
        |=> port_addr_r[0] == $past(ee_mem[`MIRC_LOC_ADDR_FIRST][6:0]))
        else $error("channel a address not copied");

    cov_load_done: cover property (wr_load ##1 load_busy ##12 load_busy ##1 !load_busy);
    cov_status_rd: cover property (stat_rd ##1 io_rdata != 8'h00);
    cov_shared_irq: cover property (|uart_irq[7:4] ##1 |host_irq);
    cov_port_sel: cover property (|uart_sel);

endmodule
`default_nettype wire

// ===== logic/mirc_defs.svh
`ifndef MIRC_DEFS_SVH
`define MIRC_DEFS_SVH

// control block offsets, low address nibble above the jumper base
`define MIRC_OFS_EE_ADDR 4'h1
`define MIRC_OFS_EE_DATA 4'h2
`define MIRC_OFS_LOAD 4'h3

// storage locations walked by a load
`define MIRC_LOC_ADDR_FIRST 4'h1
`define MIRC_LOC_ADDR_LAST 4'h8
`define MIRC_LOC_IRQ_FIRST 4'h9
`define MIRC_LOC_IRQ_SHARED 4'hd

// status register alias above the first port
`define MIRC_STATUS_ALIAS 16'h0400

// host levels 2, 3, 5, 7, 10 and 11 as a bit mask
`define MIRC_IRQ_LEGAL_MASK 16'h0cac

// reset and erased values
`define MIRC_RST_PORT_ADDR 7'h00
`define MIRC_RST_IRQ 4'h0
`define MIRC_RST_EE_ADDR 4'h0
`define MIRC_RST_JUMPERS 7'h00
`define MIRC_EE_ERASED 8'hff

`endif

// ===== logic/mirc_pkg.sv
package mirc_pkg;
    // loader states, gray along idle -> load -> idle
    typedef enum logic [0:0] {
        mirc_st_idle = 1'b0,
        mirc_st_load = 1'b1
    } mirc_state_t;
endpackage

// ===== dv/mirc_host_model.sv
`timescale 1ns/100ps
`default_nettype none

// host processor on the i/o bus: one-cycle strobes, launched on rising edges
module mirc_host_model (
    input wire logic core_clk,
    input wire logic [7:0] io_rdata,
    input wire logic io_rdata_oe,
    output var logic [15:0] io_addr,
    output var logic io_wr_strobe,
    output var logic io_rd_strobe,
    output var logic [7:0] io_wdata
);
    // idle bus at time zero
    initial begin
        io_addr = 16'hffff;
        io_wr_strobe = 1'b0;
        io_rd_strobe = 1'b0;
        io_wdata = 8'hff;
    end

    ////////////////////////////////////////////////////////////////////////
    // write pulse; address and data parked inverted once released
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        io_addr <= a;
        io_wdata <= d;
        io_wr_strobe <= 1'b1;
        @(posedge core_clk);
        io_wr_strobe <= 1'b0;
        io_addr <= ~a;
        io_wdata <= ~d;
        #1;
    endtask

    // read pulse; the answer stands just after the taking edge
    task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic oe);
        @(posedge core_clk);
        io_addr <= a;
        io_rd_strobe <= 1'b1;
        @(posedge core_clk);
        io_rd_strobe <= 1'b0;
        io_addr <= ~a;
        #1;
        d = io_rdata;
        oe = io_rdata_oe;
    endtask

    // pointer first, then data: data lands where the pointer stands
    task automatic ee_put(input logic [15:0] b, input logic [3:0] loc, input logic [7:0] d);
        wr(b + 16'h0001, {4'h0, loc});
        wr(b + 16'h0002, d);
    endtask
endmodule
`default_nettype wire

// ===== dv/mirc_top_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "mirc_defs.svh"

module mirc_top_bench;
    localparam logic [15:0] cb = 16'h0200; // jumpers 6'h20
    logic core_clk, resetn, port_disable_pin;
    logic [5:0] base_jumper_pins;
    logic [7:0] uart_irq, uart_sel, io_rdata, io_wdata, rdat;
    logic [15:0] io_addr, host_irq;
    logic io_wr_strobe, io_rd_strobe, io_rdata_oe, load_busy, roe;
    int fail_count, checks, cyc;

    mirc_top u_mirc_top (.core_clk(core_clk), .resetn(resetn), .io_addr(io_addr),
        .io_wr_strobe(io_wr_strobe), .io_rd_strobe(io_rd_strobe), .io_wdata(io_wdata),
        .base_jumper_pins(base_jumper_pins), .port_disable_pin(port_disable_pin),
        .uart_irq(uart_irq), .io_rdata(io_rdata), .io_rdata_oe(io_rdata_oe),
        .uart_sel(uart_sel), .host_irq(host_irq), .load_busy(load_busy));
    mirc_host_model u_mirc_host_model (.core_clk(core_clk), .io_rdata(io_rdata),
        .io_rdata_oe(io_rdata_oe), .io_addr(io_addr), .io_wr_strobe(io_wr_strobe),
        .io_rd_strobe(io_rd_strobe), .io_wdata(io_wdata));

    ////////////////////////////////////////////////////////////////////////
    // 25 mhz clock, hang guard well above the run length
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            fail_count++;
            test_done();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // pending lines change on an edge, routing looked at one cycle later
    task automatic set_irq(input logic [7:0] v);
        @(posedge core_clk);
        uart_irq <= v;
        @(posedge core_clk);
        #1;
    endtask
    // load write, then busy must stand exactly 13 cycles
    task automatic t_load();
        int n;
        n = 0;
        u_mirc_host_model.wr(cb + 16'h0003, 8'h00);
        repeat (30) begin
            if (load_busy === 1'b1) n++;
            @(posedge core_clk);
            #1;
        end
        chk(16'(n), 16'h000d);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // nothing stored yet: the power-on load routes no channel anywhere
    task automatic t_unprog();
        set_irq(8'hff);
        chk(host_irq, 16'h0000);
        set_irq(8'h00);
    endtask
    // every legal level over the five groups, shared group for e..h
    task automatic t_levels(input logic [3:0] l0, input logic [3:0] l4);
        logic [3:0] lv[5];
        // equal end levels mean one common level in all five locations
        if (l0 == l4) begin
            lv = '{l0, l0, l0, l0, l0};
        end else begin
            lv = '{l0, 4'h3, 4'h5, 4'h7, l4};
        end
        for (int g = 0; g < 5; g++) u_mirc_host_model.ee_put(cb, 4'h9 + 4'(g), {4'h0, lv[g]});
        t_load();
        for (int c = 0; c < 8; c++) begin
            set_irq(8'h01 << c);
            chk(host_irq, 16'h0001 << lv[(c < 4) ? c : 4]);
        end
        set_irq(8'h00);
    endtask
    // pointer and data readback, refused offsets and blank location
    task automatic t_readback();
        u_mirc_host_model.wr(cb + 16'h0001, 8'h09);
        u_mirc_host_model.rd(cb + 16'h0001, rdat, roe);
        chk(16'({roe, rdat}), 16'h0109);
        u_mirc_host_model.rd(cb + 16'h0002, rdat, roe);
        chk(16'({roe, rdat}), 16'h010b);
        u_mirc_host_model.wr(cb + 16'h0001, 8'h0e);
        u_mirc_host_model.rd(cb + 16'h0002, rdat, roe);
        chk(16'({roe, rdat}), 16'h01ff);
        u_mirc_host_model.rd(cb + 16'h0003, rdat, roe);
        chk(16'(roe), 16'h0000);
        u_mirc_host_model.rd(cb, rdat, roe);
        chk(16'(roe), 16'h0000);
    endtask
    // stored bytes are a9..a3: 0x60 is 0x300, 0x61 is 0x308
    task automatic t_ports();
        u_mirc_host_model.wr(16'h0300, 8'h55);
        chk(16'(uart_sel), 16'h0001);
        u_mirc_host_model.rd(16'h030f, rdat, roe);
        chk(16'(uart_sel), 16'h0002);
        u_mirc_host_model.rd(16'h0310, rdat, roe);
        chk(16'(uart_sel), 16'h0004);
        // the disable pin crosses a three-stage filter: let it settle
        @(posedge core_clk);
        port_disable_pin <= 1'b1;
        repeat (4) @(posedge core_clk);
        u_mirc_host_model.rd(16'h0300, rdat, roe);
        chk(16'(uart_sel), 16'h0000);
        @(posedge core_clk);
        port_disable_pin <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask
    // status alias answers with pending bits and leaves channel a unselected
    task automatic t_status();
        set_irq(8'ha5);
        u_mirc_host_model.rd(16'h0700, rdat, roe);
        chk(16'({roe, rdat}), 16'h01a5);
        chk(16'(uart_sel), 16'h0000);
        set_irq(8'h00);
    endtask

    initial begin
        fail_count = 0;
        checks = 0;
        cyc = 0;
        resetn = 1'b0;
        port_disable_pin = 1'b0;
        base_jumper_pins = 6'h20;
        uart_irq = 8'h00;
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (6) @(posedge core_clk);
        t_unprog();
        u_mirc_host_model.ee_put(cb, 4'h1, 8'h60);
        u_mirc_host_model.ee_put(cb, 4'h2, 8'h61);
        u_mirc_host_model.ee_put(cb, 4'h3, 8'h62);
        t_levels(4'h2, 4'ha);
        t_levels(4'hb, 4'hb);
        t_readback();
        t_ports();
        t_status();
        u_mirc_host_model.ee_put(cb, 4'h9, 8'h04);
        t_load();
        set_irq(8'h01);
        chk(host_irq, 16'h0000);
        test_done();
    end
endmodule
`default_nettype wire
